// [hw/vis_pkg.sv]
// constants, state encoding and timing for the voice serial audio master port
// assumes a 20 MHz system clock and a link clock whose rate is given below
package vis_pkg;

  // ----------------------------------------------------------------------
  // frame timing
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ    = 20000000;
  localparam int unsigned LINK_CLK_HZ   = 6250000;
  localparam int unsigned SAMPLE_HZ     = 16000;
  localparam int unsigned BCLK_HZ       = 512000;
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned FRAME_SLOTS   = BCLK_HZ / SAMPLE_HZ;
  localparam int unsigned BCLK_HALF_CYC = LINK_CLK_HZ / (2 * BCLK_HZ);

  // ----------------------------------------------------------------------
  // widths and fixed slot positions
  // ----------------------------------------------------------------------
  localparam int unsigned DIV_W  = 4;
  localparam int unsigned SLOT_W = 5;
  localparam logic [DIV_W-1:0]  DIV_LAST      = 4'(BCLK_HALF_CYC - 1);
  localparam logic [SLOT_W-1:0] SLOT_LAST     = 5'(FRAME_SLOTS - 1);
  localparam logic [SLOT_W-1:0] SLOT_HALF     = 5'(FRAME_SLOTS / 2);
  localparam logic [SLOT_W-1:0] SLOT_MSB      = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_LEFT_END = 5'(WORD_BITS);
  localparam logic [3:0]        BIT_IDX_MASK  = 4'(WORD_BITS - 1);

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [DIV_W-1:0]     RST_DIV  = 4'h0;
  localparam logic [SLOT_W-1:0]    RST_SLOT = 5'h1F;
  localparam logic [WORD_BITS-1:0] RST_WORD = 16'h0000;

  // word select level: left word while low, right word while high
  typedef enum logic {
    VIS_HALF_LEFT  = 1'b0,
    VIS_HALF_RIGHT = 1'b1
  } vis_half_e;

endpackage

// [hw/vis_port.sv]
// master-mode serial voice port: bit clock, word select, speaker out, mic in
// assumes the link clock runs steadily at vis_pkg::LINK_CLK_HZ; the codec follows
// Behaviour
// [R1] device makes the bit clock, codec never
// [R2] 16 kHz frames from a 512 kHz bit clock; the code makes about 520.8 kHz and 16.28 kHz from 6-cycle halves
// [R3] frame is 32 slots, two 16-bit words
// [R4] word select low first half, then high
// [R5] select low is left, high is right
// [R6] MSB first, one slot after select edge
// [R7] keep left mic word, drop right word
// [R8] same speaker sample in both words
// [R9] bit clock high and low within 45-55%
// [R10] word select is an output of the device
// [R11] codec drives mic bits on data input
// [R12] change after falling edge, sample on rising
`timescale 1ns/100ps

module vis_port (
  // system clock, reset, enable
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  input  wire logic        CE_I,
  // link clock
  input  wire logic        CLK_LINK_I,
  // speaker sample stream in
  input  wire logic [15:0] TX_DATA_I,
  input  wire logic        TX_VALID_I,
  output logic             TX_READY_O,
  // microphone sample stream out
  output logic [15:0]      RX_DATA_O,
  output logic             RX_VALID_O,
  input  wire logic        RX_READY_I,
  output logic             RX_OVERRUN_O,
  // serial audio pins
  output logic             AUDIO_BIT_CLOCK_O,
  output logic             AUDIO_FRAME_SYNC_O,
  output logic             AUDIO_SERIAL_OUT_O,
  input  wire logic        AUDIO_SERIAL_IN_I
);

  // a change counts once the second and third stage agree
  function automatic logic agree(input logic s2, input logic s3, input logic cur);
    agree = (s2 == s3) ? s3 : cur;
  endfunction

  // ----------------------------------------------------------------------
  // link domain: input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] ce_sync;
  logic [2:0] din_sync;
  logic [2:0] req_sync;
  logic       ce_l;
  logic       din_l;
  logic       req_l;
  // speaker hand-off word and request toggle, held in the system domain
  logic [vis_pkg::WORD_BITS-1:0] tx_word;
  logic                          tx_req_tog;

  always_ff @(posedge CLK_LINK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ce_sync  <= 3'h0;
      din_sync <= 3'h0;
      req_sync <= 3'h0;
      ce_l     <= 1'b0;
      din_l    <= 1'b0;
      req_l    <= 1'b0;
    end else begin
      ce_sync  <= {ce_sync[1:0], CE_I};
      din_sync <= {din_sync[1:0], AUDIO_SERIAL_IN_I};
      req_sync <= {req_sync[1:0], tx_req_tog};
      ce_l     <= agree(ce_sync[1], ce_sync[2], ce_l);
      din_l    <= agree(din_sync[1], din_sync[2], din_l);
      req_l    <= agree(req_sync[1], req_sync[2], req_l);
    end
  end

  // ----------------------------------------------------------------------
  // link domain: frame engine
  // ----------------------------------------------------------------------
  logic [vis_pkg::DIV_W-1:0]     div;
  logic                          bclk;
  logic [vis_pkg::SLOT_W-1:0]    slot;
  vis_pkg::vis_half_e            half;
  logic                          dout;
  logic [vis_pkg::WORD_BITS-1:0] spk_word;
  logic                          ack_tog;
  logic [vis_pkg::WORD_BITS-1:0] mic_sr;
  logic [vis_pkg::WORD_BITS-1:0] mic_word;
  logic                          mic_tog;

  logic [vis_pkg::DIV_W-1:0]     next_div;
  logic                          next_bclk;
  logic [vis_pkg::SLOT_W-1:0]    next_slot;
  vis_pkg::vis_half_e            next_half;
  logic                          next_dout;
  logic [vis_pkg::WORD_BITS-1:0] next_spk_word;
  logic                          next_ack_tog;
  logic [vis_pkg::WORD_BITS-1:0] next_mic_sr;
  logic [vis_pkg::WORD_BITS-1:0] next_mic_word;
  logic                          next_mic_tog;
  logic [3:0]                    bit_idx;

  always_comb begin
    next_div      = div;
    next_bclk     = bclk;
    next_slot     = slot;
    next_half     = half;
    next_dout     = dout;
    next_spk_word = spk_word;
    next_ack_tog  = ack_tog;
    next_mic_sr   = mic_sr;
    next_mic_word = mic_word;
    next_mic_tog  = mic_tog;
    bit_idx       = 4'h0;
    if (ce_l) begin
      // equal high and low half periods keep the duty at 50%, see [R9]
      if (div == vis_pkg::DIV_LAST) begin
        next_div  = vis_pkg::RST_DIV;
        next_bclk = ~bclk;                                    // see [R1] see [R2]
        if (bclk) begin
          // falling edge: advance the slot and launch select and data, see [R12]
          next_slot = (slot == vis_pkg::SLOT_LAST) ? '0 : slot + 5'h01;  // see [R3]
          case (next_slot < vis_pkg::SLOT_HALF)
            1'b1:    next_half = vis_pkg::VIS_HALF_LEFT;      // see [R4] see [R5]
            1'b0:    next_half = vis_pkg::VIS_HALF_RIGHT;     // see [R4] see [R5]
            default: next_half = vis_pkg::VIS_HALF_LEFT;
          endcase
          // take a new speaker sample at the left MSB, else repeat the last one
          if (next_slot == vis_pkg::SLOT_MSB && req_l != ack_tog) begin
            next_spk_word = tx_word;
            next_ack_tog  = req_l;
          end
          // one word index for both halves gives identical left and right, see [R8]
          bit_idx   = 4'(next_slot - vis_pkg::SLOT_MSB) & vis_pkg::BIT_IDX_MASK;  // see [R6]
          next_dout = next_spk_word[vis_pkg::BIT_IDX_MASK - bit_idx];             // see [R6]
        end else begin
          // rising edge: sample the codec's data, see [R11] see [R12]
          if (slot >= vis_pkg::SLOT_MSB && slot <= vis_pkg::SLOT_LEFT_END) begin
            next_mic_sr = {mic_sr[vis_pkg::WORD_BITS-2:0], din_l};   // see [R6]
            if (slot == vis_pkg::SLOT_LEFT_END) begin
              next_mic_word = next_mic_sr;                    // see [R7]
              next_mic_tog  = ~mic_tog;
            end
          end
        end
      end else begin
        next_div = div + 4'h1;
      end
    end
  end

  always_ff @(posedge CLK_LINK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div      <= vis_pkg::RST_DIV;
      bclk     <= 1'b0;
      slot     <= vis_pkg::RST_SLOT;
      half     <= vis_pkg::VIS_HALF_RIGHT;
      dout     <= 1'b0;
      spk_word <= vis_pkg::RST_WORD;
      ack_tog  <= 1'b0;
      mic_sr   <= vis_pkg::RST_WORD;
      mic_word <= vis_pkg::RST_WORD;
      mic_tog  <= 1'b0;
    end else begin
      div      <= next_div;
      bclk     <= next_bclk;
      slot     <= next_slot;
      half     <= next_half;
      dout     <= next_dout;
      spk_word <= next_spk_word;
      ack_tog  <= next_ack_tog;
      mic_sr   <= next_mic_sr;
      mic_word <= next_mic_word;
      mic_tog  <= next_mic_tog;
    end
  end

  // pins are driven straight from the link flops, see [R1] see [R10]
  assign AUDIO_BIT_CLOCK_O  = bclk;
  assign AUDIO_FRAME_SYNC_O = half;
  assign AUDIO_SERIAL_OUT_O = dout;

  // ----------------------------------------------------------------------
  // system domain: synchronisers from the link
  // ----------------------------------------------------------------------
  logic [2:0] ack_sync;
  logic [2:0] mic_sync;
  logic       ack_s;
  logic       mic_s;
  logic       mic_seen;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_sync <= 3'h0;
      mic_sync <= 3'h0;
      ack_s    <= 1'b0;
      mic_s    <= 1'b0;
    end else begin
      ack_sync <= {ack_sync[1:0], ack_tog};
      mic_sync <= {mic_sync[1:0], mic_tog};
      ack_s    <= agree(ack_sync[1], ack_sync[2], ack_s);
      mic_s    <= agree(mic_sync[1], mic_sync[2], mic_s);
    end
  end

  // ----------------------------------------------------------------------
  // system domain: speaker hand-off and two-entry mic buffer
  // ----------------------------------------------------------------------
  logic                          tx_ready;
  logic                          head_v;
  logic [vis_pkg::WORD_BITS-1:0] head_d;
  logic                          tail_v;
  logic [vis_pkg::WORD_BITS-1:0] tail_d;
  logic                          overrun;

  logic [vis_pkg::WORD_BITS-1:0] next_tx_word;
  logic                          next_tx_req_tog;
  logic                          next_tx_ready;
  logic                          next_mic_seen;
  logic                          next_head_v;
  logic [vis_pkg::WORD_BITS-1:0] next_head_d;
  logic                          next_tail_v;
  logic [vis_pkg::WORD_BITS-1:0] next_tail_d;
  logic                          next_overrun;

  always_comb begin
    next_tx_word    = tx_word;
    next_tx_req_tog = tx_req_tog;
    next_mic_seen   = mic_seen;
    next_head_v     = head_v;
    next_head_d     = head_d;
    next_tail_v     = tail_v;
    next_tail_d     = tail_d;
    next_overrun    = overrun;
    if (CE_I) begin
      // word held stable until the link acknowledges it at the left MSB slot
      if (TX_VALID_I && tx_ready) begin
        next_tx_word    = TX_DATA_I;
        next_tx_req_tog = ~tx_req_tog;
      end
      if (RX_READY_I && head_v) begin
        next_head_v = tail_v;
        next_head_d = tail_d;
        next_tail_v = 1'b0;
      end
      if (mic_s != mic_seen) begin
        next_mic_seen = mic_s;
        if (!next_head_v) begin
          next_head_v = 1'b1;
          next_head_d = mic_word;
        end else if (!next_tail_v) begin
          next_tail_v = 1'b1;
          next_tail_d = mic_word;
        end else begin
          next_overrun = 1'b1;
        end
      end
    end
    next_tx_ready = (next_tx_req_tog == ack_s);
  end

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_word    <= vis_pkg::RST_WORD;
      tx_req_tog <= 1'b0;
      tx_ready   <= 1'b0;
      mic_seen   <= 1'b0;
      head_v     <= 1'b0;
      head_d     <= vis_pkg::RST_WORD;
      tail_v     <= 1'b0;
      tail_d     <= vis_pkg::RST_WORD;
      overrun    <= 1'b0;
    end else begin
      tx_word    <= next_tx_word;
      tx_req_tog <= next_tx_req_tog;
      tx_ready   <= next_tx_ready;
      mic_seen   <= next_mic_seen;
      head_v     <= next_head_v;
      head_d     <= next_head_d;
      tail_v     <= next_tail_v;
      tail_d     <= next_tail_d;
      overrun    <= next_overrun;
    end
  end

  assign TX_READY_O   = tx_ready;
  assign RX_VALID_O   = head_v;
  assign RX_DATA_O    = head_d;
  assign RX_OVERRUN_O = overrun;

endmodule

// [verification/vis_port_chk.sv]
// port assertions for the serial voice port
// assumes CE_I stays high whenever the link runs
`timescale 1ns/100ps
module vis_port_chk (
  // clocks, reset and sample streams
  input wire logic        CLK_SYS_I,
  input wire logic        CLK_LINK_I,
  input wire logic        RESETN_I,
  input wire logic        CE_I,
  input wire logic        TX_VALID_I,
  input wire logic        TX_READY_O,
  input wire logic [15:0] RX_DATA_O,
  input wire logic        RX_VALID_O,
  input wire logic        RX_READY_I,
  input wire logic        RX_OVERRUN_O,
  // serial pins
  input wire logic        AUDIO_BIT_CLOCK_O,
  input wire logic        AUDIO_FRAME_SYNC_O,
  input wire logic        AUDIO_SERIAL_OUT_O
);
  logic        pb;
  logic        pf;
  logic        armed;
  logic [4:0]  cnt;
  logic [15:0] hist;
  // slot count from frame start at each falling bit clock, bits seen at each rising bit clock
  always_ff @(posedge CLK_LINK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pb    <= 1'b0;
      pf    <= 1'b1;
      armed <= 1'b0;
      cnt   <= 5'h00;
      hist  <= 16'h0000;
    end else begin
      pb <= AUDIO_BIT_CLOCK_O;
      pf <= AUDIO_FRAME_SYNC_O;
      if (pb && !AUDIO_BIT_CLOCK_O)
        cnt <= (pf && !AUDIO_FRAME_SYNC_O) ? 5'h00 : cnt + 5'h01;
      if (pf && !AUDIO_FRAME_SYNC_O)
        armed <= 1'b1;
      if (!pb && AUDIO_BIT_CLOCK_O)
        hist <= {hist[14:0], AUDIO_SERIAL_OUT_O};
    end
  end
  a_bclk_high_len: assert property (@(posedge CLK_LINK_I) disable iff (!RESETN_I)
    $rose(AUDIO_BIT_CLOCK_O) |-> AUDIO_BIT_CLOCK_O [*6] ##1 !AUDIO_BIT_CLOCK_O)
    else $error("bit clock high phase length");
  a_bclk_low_len: assert property (@(posedge CLK_LINK_I) disable iff (!RESETN_I)
    $fell(AUDIO_BIT_CLOCK_O) |-> !AUDIO_BIT_CLOCK_O [*6] ##1 AUDIO_BIT_CLOCK_O)
    else $error("bit clock low phase length");
  a_pins_hold_high: assert property (@(posedge CLK_LINK_I) disable iff (!RESETN_I)
    AUDIO_BIT_CLOCK_O && $past(AUDIO_BIT_CLOCK_O)
    |-> $stable(AUDIO_FRAME_SYNC_O) && $stable(AUDIO_SERIAL_OUT_O))
    else $error("pin moved while bit clock high");
  a_frame_len: assert property (@(posedge CLK_LINK_I) disable iff (!RESETN_I)
    armed && pf && !AUDIO_FRAME_SYNC_O |-> cnt == 5'h1F)
    else $error("frame not 32 slots");
  a_half_switch: assert property (@(posedge CLK_LINK_I) disable iff (!RESETN_I)
    !pf && AUDIO_FRAME_SYNC_O |-> cnt == 5'h0F)
    else $error("select rose off mid frame");
  a_right_copy: assert property (@(posedge CLK_LINK_I) disable iff (!RESETN_I)
    !pb && AUDIO_BIT_CLOCK_O && cnt > 5'h10 |-> AUDIO_SERIAL_OUT_O == hist[15])
    else $error("right word differs from left");
  a_take_ready: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    TX_VALID_I && TX_READY_O && CE_I |=> !TX_READY_O [*8])
    else $error("ready back too soon");
  a_rx_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    RX_VALID_O && !RX_READY_I |=> RX_VALID_O && $stable(RX_DATA_O))
    else $error("mic word not held");
  a_ovr_sticky: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
    RX_OVERRUN_O |=> RX_OVERRUN_O)
    else $error("overrun flag cleared");
endmodule
bind vis_port vis_port_chk u_chk (.CLK_SYS_I, .CLK_LINK_I, .RESETN_I, .CE_I, .TX_VALID_I,
  .TX_READY_O, .RX_DATA_O, .RX_VALID_O, .RX_READY_I, .RX_OVERRUN_O, .AUDIO_BIT_CLOCK_O,
  .AUDIO_FRAME_SYNC_O, .AUDIO_SERIAL_OUT_O);

// [verification/vis_codec_model.sv]
// behavioural codec on the far side of the serial voice port
// assumes it only follows the bit clock and select it is given
`timescale 1ns/100ps
module vis_codec_model (
  // serial pins
  input  wire logic        bclk_i,
  input  wire logic        fs_i,
  input  wire logic        sdo_i,
  output logic             sdi_o = 1'b0,
  // mic word sent, speaker words caught
  input  wire logic [15:0] mic_i,
  output logic [15:0]      left_o,
  output logic [15:0]      right_o
);
  logic fs_d = 1'b1;
  logic fs_n = 1'b1;
  int   slot = 0;
  // channel follows the select of the slot before, so MSB lags select
  always @(posedge bclk_i) begin
    if (fs_d)
      right_o <= {right_o[14:0], sdo_i};
    else
      left_o <= {left_o[14:0], sdo_i};
    fs_d <= fs_i;
  end
  // left word true, right word inverted so a kept right word shows
  always @(negedge bclk_i) begin
    #10;
    slot = (fs_n && !fs_i) ? 0 : slot + 1;
    fs_n = fs_i;
    sdi_o = (slot >= 1 && slot <= 16) ? mic_i[16 - slot] : ~mic_i[(32 - slot) & 15];
  end
endmodule

// [verification/tb.sv]
// self-checking bench for the serial voice port with a codec model
// assumes a 20 MHz system clock and a free 160 ns link clock
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module tb;
  logic        clk, lclk, rst_n, ce, tx_v, tx_rdy, rx_v, rx_rdy, ovr, bclk, fs, sdo, sdi;
  logic [15:0] tx_d, rx_d, mic, spk_l, spk_r;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cyc = 0;
  vis_port dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce), .CLK_LINK_I(lclk),
    .TX_DATA_I(tx_d), .TX_VALID_I(tx_v), .TX_READY_O(tx_rdy), .RX_DATA_O(rx_d),
    .RX_VALID_O(rx_v), .RX_READY_I(rx_rdy), .RX_OVERRUN_O(ovr), .AUDIO_BIT_CLOCK_O(bclk),
    .AUDIO_FRAME_SYNC_O(fs), .AUDIO_SERIAL_OUT_O(sdo), .AUDIO_SERIAL_IN_I(sdi));
  vis_codec_model codec (.bclk_i(bclk), .fs_i(fs), .sdo_i(sdo), .sdi_o(sdi), .mic_i(mic),
    .left_o(spk_l), .right_o(spk_r));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #37;
    forever #80 lclk = ~lclk;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ends just after the last bit of a frame was caught by the codec
  task automatic frame_end;
    @(negedge fs);
    @(posedge bclk);
    #1;
  endtask
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk);
    tx_d <= w;
    tx_v <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (tx_rdy !== 1'b1 && n < 3000);
    `CHK(tx_rdy, 1'b1)
    @(posedge clk);
    tx_v <= 1'b0;
  endtask
  task automatic pop(input logic [15:0] w);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rx_v !== 1'b1 && n < 3000);
    `CHK(rx_d, w)
    @(posedge clk);
    rx_rdy <= 1'b1;
    @(posedge clk);
    rx_rdy <= 1'b0;
  endtask
  task automatic test_tx;
    send(16'hA5C3);
    send(16'h8001);
    frame_end;
    `CHK({spk_l, spk_r}, {16'hA5C3, 16'hA5C3})
    frame_end;
    `CHK({spk_l, spk_r}, {16'h8001, 16'h8001})
    frame_end;
    `CHK(spk_r, 16'h8001)
    $display("test tx done");
  endtask
  task automatic test_rx;
    mic = 16'h3C5A;
    @(posedge clk);
    rx_rdy <= 1'b1;
    frame_end;
    frame_end;
    @(posedge clk);
    rx_rdy <= 1'b0;
    pop(16'h3C5A);
    $display("test rx done");
  endtask
  task automatic test_overrun;
    `CHK(ovr, 1'b0)
    mic = 16'hF00F;
    repeat (4) frame_end;
    `CHK(ovr, 1'b1)
    pop(16'hF00F);
    pop(16'hF00F);
    repeat (2) @(negedge clk);
    `CHK(rx_v, 1'b0)
    $display("test overrun done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    tx_v = 1'b0;
    tx_d = 16'h0000;
    // mic words drain during the speaker test so no overrun is left behind
    rx_rdy = 1'b1;
    mic = 16'h0000;
    repeat (5) @(posedge clk);
    `CHK({bclk, fs, sdo, tx_rdy, rx_v, ovr}, 6'h10)
    @(posedge clk);
    rst_n <= 1'b1;
    test_tx;
    test_rx;
    test_overrun;
    close_out;
  end
endmodule
